// file: logic/ddr2_timing_pkg.sv
// Purpose: Shared constants and types for the DDR2 command timing link
// Assumes: 50 MHz clock, one command per cycle on the link
// Notes: Nanosecond figures round up to cycles, except MOD_PS and OIT_PS, which round down with a minimum of one
package ddr2_timing_pkg;
  localparam int CLK_PS = 20000;
  localparam int RRD_PS = 7500;
  localparam int WR_PS = 15000;
  localparam int WTR_PS = 10000;
  localparam int RTP_PS = 7500;
  localparam int RFC_PS = 75000;
  localparam int XSNR_EXTRA_PS = 10000;
  localparam int MOD_PS = 12000;
  localparam int OIT_PS = 12000;
  localparam int RP_PS = 15000;
  localparam int CCD_CK = 2;
  localparam int CKE_CK = 3;
  localparam int XSRD_CK = 200;
  localparam int XP_CK = 2;
  localparam int XARD_CK = 2;
  localparam int XARDS_CK = 6;
  localparam int AOND_CK = 2;
  localparam int AOFD_CK = 3;
  localparam int ANPD_CK = 3;
  localparam int AXPD_CK = 8;
  localparam int MRD_CK = 2;
  localparam int BANKS = 4;
  localparam int BA_W = 2;
  localparam int ADDR_W = 13;
  localparam int CNT_W = 8;
  localparam int APD_SLOW_BIT = 12;
  localparam int DQS_SE_BIT = 10;
  localparam int ODT_EN_BIT = 2;
  localparam int OCD_BIT = 7;

  function automatic int ceil_cyc(input int ps);
    ceil_cyc = (ps + CLK_PS - 1) / CLK_PS;
    if (ceil_cyc < 1) ceil_cyc = 1;
  endfunction

  localparam int RRD_CK = ceil_cyc(RRD_PS);
  localparam int WR_CK = ceil_cyc(WR_PS);
  localparam int WTR_CK = ceil_cyc(WTR_PS);
  localparam int RTP_CK = ceil_cyc(RTP_PS);
  localparam int RP_CK = ceil_cyc(RP_PS);
  localparam int XSNR_CK = ceil_cyc(RFC_PS + XSNR_EXTRA_PS);
  localparam int MOD_CK = MOD_PS / CLK_PS < 1 ? 1 : MOD_PS / CLK_PS;
  localparam int OIT_CK = OIT_PS / CLK_PS < 1 ? 1 : OIT_PS / CLK_PS;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_RD = 3'h2,
    CMD_WR = 3'h3,
    CMD_PRE = 3'h4,
    CMD_MRS = 3'h5,
    CMD_EMRS = 3'h6
  } cmd_t;
endpackage

// file: logic/ddr2_link_if.sv
// Purpose: Command, clock enable, termination and strobe link
// Assumes: Both ends share clk
// Notes: Strobe and its complement are each split into out and enable
`timescale 1ns/1ps
interface ddr2_link_if;
  import ddr2_timing_pkg::*;
  logic cke;
  cmd_t cmd;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic auto_pre;
  logic odt;
  logic dqs_o;
  logic dqs_oe;
  logic dqs_n_o;
  logic dqs_n_oe;
  logic odt_on;
  logic ocd_drive;
  modport dev (input cke, cmd, ba, addr, auto_pre, odt,
    output dqs_o, dqs_oe, dqs_n_o, dqs_n_oe, odt_on, ocd_drive);
  modport ctl (output cke, cmd, ba, addr, auto_pre, odt,
    input dqs_o, dqs_oe, dqs_n_o, dqs_n_oe, odt_on, ocd_drive);
endinterface

// file: logic/gap_timer.sv
// Purpose: Loadable down-counter that reports when a gap has elapsed
// Assumes: Load value at least one
// Notes: A larger pending load never shortens the wait
`timescale 1ns/1ps
module gap_timer #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (cnt_reg != '0) cnt_next = cnt_reg - 1'b1;
    // Keep the longer of the running and new gap
    if (load && value - 1'b1 > cnt_next) cnt_next = value - 1'b1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt_reg <= '0;
    else cnt_reg <= cnt_next;
  end

  assign done = (cnt_reg == '0);
endmodule

// file: logic/ddr2_ctl_end.sv
// Purpose: Controller end: issues user commands only when every spacing is met
// Assumes: One user request held until accepted
// Notes: Gaps tracked by down-counters, per bank where the gap is per bank
//
// Function
// - Activates to different banks spaced by 7.5 ns
// - Column commands at least two cycles apart
// - Write recovery before precharge; auto precharge adds tRP
// - Read waits write-to-read delay after write
// - Precharge waits 7.5 ns after read
// - CKE held three cycles per level
// - Self refresh exit waits tRFC+10ns, reads 200
// - Precharge power-down exit waits two cycles
// - Active power-down exit: fast 2, slow 6-AL
// - Device turns termination on two clocks later
// - Device turns termination off 2.5 clocks later; the device end takes 3
// - Three cycles from ODT change to power-down
// - Eight cycles after power-down exit before power-down re-entry, cut to three by an ODT change; ODT changes are not held off
// - Mode register set spaced two cycles
// - Termination setting update within 12 ns; the device end takes one 20 ns cycle
// - Drive-mode outputs start within 12 ns; the device end takes one 20 ns cycle
// - Clock kept running tIS+tCK+tIH after CKE low
// - Strobe single-ended or differential by mode bit
// - Address bit 12 picks power-down exit speed
// - Read to precharge at least AL plus BL/2
`timescale 1ns/1ps
module ddr2_ctl_end #(
  parameter int AL = 0,
  parameter int BL = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // User request
  input wire logic req_valid,
  input wire ddr2_timing_pkg::cmd_t req_cmd,
  input wire logic [ddr2_timing_pkg::BA_W-1:0] req_ba,
  input wire logic [ddr2_timing_pkg::ADDR_W-1:0] req_addr,
  input wire logic req_auto_pre,
  output logic req_ready,
  // Power and termination requests
  input wire logic pd_req,
  input wire logic sr_mode,
  input wire logic odt_req,
  output logic clk_run,
  // Link
  ddr2_link_if.ctl link
);
  import ddr2_timing_pkg::*;

  localparam int RTP_ALL = (RTP_CK > AL + BL / 2) ? RTP_CK : AL + BL / 2;
  localparam int XARDS_EFF = (XARDS_CK - AL < 1) ? 1 : XARDS_CK - AL;

  typedef struct packed {
    logic cke;
    cmd_t cmd;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic auto_pre;
    logic odt;
    logic apd_slow;
    logic in_sr;
    logic [CNT_W-1:0] cke_cnt;
    logic [CNT_W-1:0] odt_cnt;
    logic [CNT_W-1:0] stop_cnt;
  } state_t;

  state_t s_reg;
  state_t s_next;

  // Gap timers: index 0..3 precharge per bank, 4..7 activate per bank
  localparam int NT = 2 * BANKS + 5;
  localparam int T_COL = 2 * BANKS;
  localparam int T_RD = 2 * BANKS + 1;
  localparam int T_ACT = 2 * BANKS + 2;
  localparam int T_ANY = 2 * BANKS + 3;
  localparam int T_RDX = 2 * BANKS + 4;
  logic [NT-1:0] t_load;
  logic [NT-1:0][CNT_W-1:0] t_val;
  logic [NT-1:0] t_done;

  genvar gi;
  generate
    for (gi = 0; gi < NT; gi++) begin : g_tim
      gap_timer #(.W(CNT_W)) u_tim (
        .clk(clk),
        .rst(rst),
        .load(t_load[gi]),
        .value(t_val[gi]),
        .done(t_done[gi])
      );
    end
  endgenerate

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n);
  endfunction

  logic issue;
  logic ok;
  logic want_cke;

  always_comb begin
    s_next = s_reg;
    s_next.cmd = CMD_NOP;
    t_load = '0;
    t_val = '0;
    ok = t_done[T_ANY];
    want_cke = !pd_req;
    case (req_cmd)
      CMD_ACT: ok = ok && t_done[T_ACT] && t_done[BANKS + req_ba];
      CMD_RD: ok = ok && t_done[T_COL] && t_done[T_RD] && t_done[T_RDX];
      CMD_WR: ok = ok && t_done[T_COL];
      CMD_PRE: ok = ok && t_done[req_ba];
      CMD_MRS: ok = ok;
      CMD_EMRS: ok = ok;
      default: ok = 1'b0;
    endcase
    ok = ok && s_reg.cke && want_cke;
    issue = req_valid && ok;
    if (issue) begin
      s_next.cmd = req_cmd;
      s_next.ba = req_ba;
      s_next.addr = req_addr;
      s_next.auto_pre = req_auto_pre;
      case (req_cmd)
        CMD_ACT: begin
          t_load[T_ACT] = 1'b1;
          t_val[T_ACT] = cyc(RRD_CK);
        end
        CMD_RD: begin
          t_load[T_COL] = 1'b1;
          t_val[T_COL] = cyc(CCD_CK);
          t_load[req_ba] = 1'b1;
          t_val[req_ba] = cyc(RTP_ALL);
        end
        CMD_WR: begin
          t_load[T_COL] = 1'b1;
          t_val[T_COL] = cyc(CCD_CK);
          t_load[T_RD] = 1'b1;
          t_val[T_RD] = cyc(WTR_CK + BL / 2);
          t_load[req_ba] = 1'b1;
          t_val[req_ba] = cyc(WR_CK + BL / 2);
          if (req_auto_pre) begin
            t_load[BANKS + req_ba] = 1'b1;
            t_val[BANKS + req_ba] = cyc(WR_CK + RP_CK + BL / 2);
          end
        end
        CMD_MRS: begin
          t_load[T_ANY] = 1'b1;
          t_val[T_ANY] = cyc(MRD_CK);
          s_next.apd_slow = req_addr[APD_SLOW_BIT];
        end
        CMD_EMRS: begin
          t_load[T_ANY] = 1'b1;
          t_val[T_ANY] = cyc(MRD_CK);
        end
        default: ;
      endcase
    end
    // Clock enable held a minimum time per level
    if (s_reg.cke_cnt != '0) s_next.cke_cnt = s_reg.cke_cnt - 1'b1;
    if (s_reg.odt_cnt != '0) s_next.odt_cnt = s_reg.odt_cnt - 1'b1;
    if (s_reg.odt != odt_req && s_reg.cke) begin
      s_next.odt = odt_req;
      s_next.odt_cnt = cyc(ANPD_CK);
    end
    if (s_reg.cke_cnt == '0 && !issue) begin
      if (s_reg.cke && !want_cke && s_reg.odt_cnt == '0 && s_reg.odt == odt_req) begin
        s_next.cke = 1'b0;
        s_next.cke_cnt = cyc(CKE_CK);
        s_next.in_sr = sr_mode;
        s_next.stop_cnt = cyc(2);
      end else if (!s_reg.cke && want_cke) begin
        s_next.cke = 1'b1;
        s_next.cke_cnt = cyc(CKE_CK);
        t_load[T_ANY] = 1'b1;
        t_load[T_RDX] = 1'b1;
        if (s_reg.in_sr) begin
          t_val[T_ANY] = cyc(XSNR_CK);
          t_val[T_RDX] = cyc(XSRD_CK);
        end else begin
          t_val[T_ANY] = cyc(XP_CK);
          t_val[T_RDX] = s_reg.apd_slow ? cyc(XARDS_EFF) : cyc(XARD_CK);
        end
        s_next.odt_cnt = cyc(AXPD_CK);
      end
    end
    if (s_reg.stop_cnt != '0) s_next.stop_cnt = s_reg.stop_cnt - 1'b1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.cke <= 1'b1;
      s_reg.cmd <= CMD_NOP;
    end else begin
      s_reg <= s_next;
    end
  end

  assign req_ready = ok;
  // Clock may stop only once the hold after CKE low has run out
  assign clk_run = s_reg.cke || s_reg.stop_cnt != '0;
  assign link.cke = s_reg.cke;
  assign link.cmd = s_reg.cmd;
  assign link.ba = s_reg.ba;
  assign link.addr = s_reg.addr;
  assign link.auto_pre = s_reg.auto_pre;
  assign link.odt = s_reg.odt;
endmodule

// file: logic/ddr2_dev_end.sv
// Purpose: Device end: termination switching, mode bits, strobe mode
// Assumes: Controller keeps its spacing
// Notes: Half-cycle turn-off rounds up to whole clocks
`timescale 1ns/1ps
module ddr2_dev_end (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // User side
  input wire logic dqs_drive,
  input wire logic dqs_val,
  output logic dqs_diff,
  output logic in_pd,
  // Link
  ddr2_link_if.dev link
);
  import ddr2_timing_pkg::*;

  typedef struct packed {
    logic [AOFD_CK-1:0] odt_pipe;
    logic odt_on;
    logic odt_allow;
    logic odt_allow_pend;
    logic [CNT_W-1:0] mod_cnt;
    logic dqs_diff;
    logic ocd;
    logic ocd_pend;
    logic [CNT_W-1:0] oit_cnt;
  } state_t;

  state_t s_reg;
  state_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.odt_pipe = {s_reg.odt_pipe[AOFD_CK-2:0], link.odt};
    if (!link.cke) begin
      s_next.odt_on = link.odt && s_reg.odt_allow;
    end else if (s_reg.odt_pipe[AOND_CK-1] && !s_reg.odt_on) begin
      s_next.odt_on = s_reg.odt_allow;
    end else if (!s_reg.odt_pipe[AOFD_CK-1] && !s_reg.odt_pipe[AOND_CK-1]) begin
      s_next.odt_on = 1'b0;
    end
    if (link.cmd == CMD_EMRS) begin
      s_next.odt_allow_pend = link.addr[ODT_EN_BIT];
      s_next.mod_cnt = CNT_W'(MOD_CK);
      s_next.dqs_diff = !link.addr[DQS_SE_BIT];
      s_next.ocd_pend = link.addr[OCD_BIT];
      s_next.oit_cnt = CNT_W'(OIT_CK);
    end
    if (s_reg.mod_cnt != '0) begin
      s_next.mod_cnt = s_reg.mod_cnt - 1'b1;
      if (s_reg.mod_cnt == 8'h01) s_next.odt_allow = s_reg.odt_allow_pend;
    end
    if (s_reg.oit_cnt != '0) begin
      s_next.oit_cnt = s_reg.oit_cnt - 1'b1;
      if (s_reg.oit_cnt == 8'h01) s_next.ocd = s_reg.ocd_pend;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.dqs_diff <= 1'b1;
      s_reg.odt_allow <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.odt_on = s_reg.odt_on;
  assign link.ocd_drive = s_reg.ocd;
  assign link.dqs_o = dqs_val;
  assign link.dqs_oe = dqs_drive || s_reg.ocd;
  assign link.dqs_n_o = !dqs_val;
  assign link.dqs_n_oe = (dqs_drive || s_reg.ocd) && s_reg.dqs_diff;
  assign dqs_diff = s_reg.dqs_diff;
  assign in_pd = !link.cke;
endmodule

// file: verification/ddr2_link_assertions.sv
// Purpose: Timing checks on the link between controller end and device end
// Assumes: One clock, asynchronous active high reset
// Notes: Mode bits are tracked in helper flops that follow the device's own update delays
`timescale 1ns/1ps
module ddr2_link_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link
  input wire logic cke,
  input wire ddr2_timing_pkg::cmd_t cmd,
  input wire logic [ddr2_timing_pkg::ADDR_W-1:0] addr,
  input wire logic odt,
  input wire logic dqs_o,
  input wire logic dqs_oe,
  input wire logic dqs_n_o,
  input wire logic dqs_n_oe,
  input wire logic odt_on,
  input wire logic ocd_drive
);
  import ddr2_timing_pkg::*;
  logic odt_pend_reg, odt_en_reg, se_reg;
  // ==========
  // Mode tracking
  // Strobe mode switches on the sampling edge, termination enable one edge later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      odt_pend_reg <= 1'h1;
      odt_en_reg <= 1'h1;
      se_reg <= 1'h0;
    end else begin
      if (cmd == CMD_EMRS) begin
        odt_pend_reg <= addr[ODT_EN_BIT];
        se_reg <= addr[DQS_SE_BIT];
      end
      odt_en_reg <= odt_pend_reg;
    end
  end
  // ==========
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_ccd;
    (cmd == CMD_RD || cmd == CMD_WR) |=> !(cmd == CMD_RD || cmd == CMD_WR);
  endproperty
  a_ccd: assert property (p_ccd) else $error("column commands too close");
  property p_mrd;
    (cmd == CMD_MRS || cmd == CMD_EMRS) |=> cmd == CMD_NOP;
  endproperty
  a_mrd: assert property (p_mrd) else $error("mode set followed too soon");
  property p_cke_hi;
    $rose(cke) |=> cke [*2];
  endproperty
  a_cke_hi: assert property (p_cke_hi) else $error("clock enable high too short");
  property p_cke_lo;
    $fell(cke) |=> !cke [*2];
  endproperty
  a_cke_lo: assert property (p_cke_lo) else $error("clock enable low too short");
  property p_xp;
    $rose(cke) |-> cmd == CMD_NOP ##1 cmd == CMD_NOP;
  endproperty
  a_xp: assert property (p_xp) else $error("command too soon after exit");
  property p_anpd;
    $changed(odt) && cke |-> cke [*3];
  endproperty
  a_anpd: assert property (p_anpd) else $error("power-down too soon after odt change");
  property p_aond;
    $rose(odt) && cke && odt_en_reg |=> !odt_on [*2] ##1 odt_on;
  endproperty
  a_aond: assert property (p_aond) else $error("termination on delay wrong");
  property p_aofd;
    $fell(odt) && cke && odt_en_reg |=> odt_on [*3] ##1 !odt_on;
  endproperty
  a_aofd: assert property (p_aofd) else $error("termination off delay wrong");
  property p_oit;
    cmd == CMD_EMRS |-> ##2 ocd_drive == $past(addr[OCD_BIT], 2);
  endproperty
  a_oit: assert property (p_oit) else $error("drive mode late");
  property p_dqs_se;
    dqs_oe && se_reg |-> !dqs_n_oe;
  endproperty
  a_dqs_se: assert property (p_dqs_se) else $error("complement driven in single mode");
  property p_dqs_diff;
    dqs_oe && !se_reg |-> dqs_n_oe && dqs_n_o == !dqs_o;
  endproperty
  a_dqs_diff: assert property (p_dqs_diff) else $error("complement strobe wrong");
  c_pd: cover property ($fell(cke));
  c_odt: cover property ($rose(odt_on));
  c_mrd: cover property (cmd == CMD_EMRS ##2 cmd == CMD_EMRS);
endmodule

// file: verification/ddr2_command_timing_rules_test.sv
// Purpose: Bench for both ends joined by the link
// Assumes: 50 MHz clock, AL 0, BL 4
// Notes: Gaps counted in clock edges between link events
`timescale 1ns/1ps
module ddr2_command_timing_rules_test;
  import ddr2_timing_pkg::*;
  localparam int AL = 0;
  localparam int BL = 4;
  logic clk, rst, req_valid, req_auto_pre, req_ready, pd_req, sr_mode, odt_req, clk_run;
  logic dqs_drive, dqs_val, dqs_diff, in_pd;
  cmd_t req_cmd;
  logic [BA_W-1:0] req_ba;
  logic [ADDR_W-1:0] req_addr;
  int n_fail, checks_done, cyc;
  ddr2_link_if link ();
  ddr2_ctl_end #(.AL(AL), .BL(BL)) i_ddr2_ctl_end (.clk(clk), .rst(rst), .req_valid(req_valid), .req_cmd(req_cmd),
    .req_ba(req_ba), .req_addr(req_addr), .req_auto_pre(req_auto_pre), .req_ready(req_ready), .pd_req(pd_req),
    .sr_mode(sr_mode), .odt_req(odt_req), .clk_run(clk_run), .link(link));
  ddr2_dev_end i_ddr2_dev_end (.clk(clk), .rst(rst), .dqs_drive(dqs_drive), .dqs_val(dqs_val),
    .dqs_diff(dqs_diff), .in_pd(in_pd), .link(link));
  ddr2_link_assertions i_ddr2_link_assertions (.clk(clk), .rst(rst), .cke(link.cke), .cmd(link.cmd),
    .addr(link.addr), .odt(link.odt), .dqs_o(link.dqs_o), .dqs_oe(link.dqs_oe), .dqs_n_o(link.dqs_n_o),
    .dqs_n_oe(link.dqs_n_oe), .odt_on(link.odt_on), .ocd_drive(link.ocd_drive));
  // ==========
  // Helpers
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'h1) begin
      n_fail++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic sig(input int k);
    if (k == 0) return link.odt;
    if (k == 1) return link.odt_on;
    return link.cke;
  endfunction
  task automatic wait_sig(input int k, input logic v);
    int n;
    for (n = 0; n < 300 && sig(k) !== v; n++) tick(1);
    if (n == 300) begin
      chk(1'h0, "wait timed out");
      stop_test();
    end
  endtask
  // Holds valid up on return so back-to-back requests never toggle it
  task automatic issue(input cmd_t c, input logic [BA_W-1:0] b, input logic [ADDR_W-1:0] a, input logic ap,
    output int t);
    int n;
    req_valid = 1;
    req_cmd = c;
    req_ba = b;
    req_addr = a;
    req_auto_pre = ap;
    // Let ready settle on the new request before looking at it
    #1;
    for (n = 0; n < 400 && req_ready !== 1'h1; n++) tick(1);
    if (n == 400) begin
      chk(1'h0, "request never accepted");
      stop_test();
    end
    tick(1);
    t = cyc;
    chk(link.cmd === c && link.ba === b, "command not on link");
  endtask
  // ==========
  // Scenarios
  task automatic sc_mode();
    int t1, t2;
    issue(CMD_EMRS, 0, 13'h0084, 0, t1);
    issue(CMD_EMRS, 0, 13'h0404, 0, t2);
    chk(t2 - t1 == MRD_CK, "mode set spacing");
    chk(link.ocd_drive === 1'h1, "drive mode not entered");
    req_valid = 0;
    tick(3);
    chk(link.ocd_drive === 1'h0 && dqs_diff === 1'h0, "single strobe not set");
    dqs_drive = 1;
    tick(1);
    chk(link.dqs_oe === 1'h1 && link.dqs_n_oe === 1'h0 && link.dqs_o === 1'h1, "single strobe");
    dqs_drive = 0;
    issue(CMD_EMRS, 0, 13'h0004, 0, t1);
    req_valid = 0;
    tick(3);
    dqs_drive = 1;
    tick(1);
    chk(dqs_diff === 1'h1 && link.dqs_n_oe === 1'h1 && link.dqs_n_o === 1'h0, "differential strobe");
    dqs_drive = 0;
  endtask
  task automatic sc_odt();
    int t;
    odt_req = 1;
    wait_sig(0, 1);
    t = cyc;
    wait_sig(1, 1);
    // One extra edge: the device samples odt one edge after it is launched
    chk(cyc - t == AOND_CK + 1, "termination on delay");
    odt_req = 0;
    wait_sig(0, 0);
    t = cyc;
    wait_sig(1, 0);
    chk(cyc - t == AOFD_CK + 1, "termination off delay");
  endtask
  task automatic sc_pair(input cmd_t c1, input cmd_t c2, input logic [BA_W-1:0] b2, input logic ap, input int gap);
    int t1, t2;
    tick(8);
    issue(c1, 0, 0, ap, t1);
    issue(c2, b2, 0, 0, t2);
    req_valid = 0;
    chk(t2 - t1 == gap, "command spacing");
  endtask
  task automatic sc_pd(input logic sr, input logic slow, input cmd_t c, input int gap);
    int t, t2;
    issue(CMD_MRS, 0, slow ? 13'h1000 : 13'h0000, 0, t);
    req_valid = 0;
    sr_mode = sr;
    pd_req = 1;
    wait_sig(2, 0);
    t = cyc;
    chk(clk_run === 1'h1 && in_pd === 1'h1, "power-down entry");
    tick(1);
    chk(clk_run === 1'h1, "clock stopped early");
    tick(4);
    chk(clk_run === 1'h0, "clock not released after hold");
    pd_req = 0;
    wait_sig(2, 1);
    chk(cyc - t >= CKE_CK, "clock enable low too short");
    t = cyc;
    issue(c, 0, 0, 0, t2);
    req_valid = 0;
    chk(t2 - t == gap, "exit spacing");
  endtask
  // ==========
  // Main sequence
  initial begin
    {rst, req_valid, req_auto_pre, pd_req, sr_mode, odt_req, dqs_drive} = 7'h7F & 7'h40;
    dqs_val = 1;
    req_cmd = CMD_NOP;
    req_ba = 0;
    req_addr = 0;
    n_fail = 0;
    checks_done = 0;
    tick(2);
    rst = 0;
    chk(link.cke === 1'h1 && link.odt_on === 1'h0 && dqs_diff === 1'h1 && clk_run === 1'h1, "reset values");
    sc_mode();
    sc_odt();
    sc_pair(CMD_ACT, CMD_ACT, 1, 0, RRD_CK);
    sc_pair(CMD_RD, CMD_RD, 0, 0, CCD_CK);
    sc_pair(CMD_WR, CMD_RD, 0, 0, WTR_CK + BL / 2);
    sc_pair(CMD_WR, CMD_PRE, 0, 0, WR_CK + BL / 2);
    sc_pair(CMD_RD, CMD_PRE, 0, 0, AL + BL / 2);
    sc_pair(CMD_WR, CMD_ACT, 0, 1, BL / 2 + WR_CK + RP_CK);
    sc_pd(0, 0, CMD_ACT, XP_CK);
    sc_pd(0, 0, CMD_RD, XARD_CK);
    sc_pd(0, 1, CMD_RD, XARDS_CK - AL);
    sc_pd(1, 0, CMD_ACT, XSNR_CK);
    sc_pd(1, 0, CMD_RD, XSRD_CK);
    stop_test();
  end
endmodule
